/* src/sce_pkg.sv */
// Shared constants for the command decoder and function-enable link
package sce_pkg;

    // ------------------------------------------------------------------
    // Command byte layout
    // ------------------------------------------------------------------
    localparam int unsigned CMD_FLAG_BIT   = 7;
    localparam int unsigned CMD_TYPE_MSB   = 6;
    localparam int unsigned CMD_TYPE_LSB   = 5;
    localparam int unsigned CMD_FIELD_MSB  = 4;
    localparam int unsigned CMD_FIELD_LSB  = 0;

    localparam logic [1:0] TYPE_REPEAT     = 2'h0;
    localparam logic [1:0] TYPE_AUTO_INC   = 2'h1;
    localparam logic [1:0] TYPE_RESERVED   = 2'h2;
    localparam logic [1:0] TYPE_SPECIAL    = 2'h3;

    localparam logic [4:0] SF_INT_CLEAR    = 5'h06;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [4:0] ADDR_FUNCTION_ENABLE = 5'h00;
    localparam logic [4:0] POINTER_RESET        = 5'h00;
    localparam logic [7:0] ENABLE_RESET         = 8'h00;
    localparam logic [7:0] ENABLE_WRITABLE_MASK = 8'h1B;
    localparam logic [7:0] UNMAPPED_READ_VALUE  = 8'h00;

    localparam int unsigned EN_COLOR_INT_BIT  = 4;
    localparam int unsigned EN_WAIT_TIMER_BIT = 3;
    localparam int unsigned EN_CONVERSION_BIT = 1;
    localparam int unsigned EN_OSC_POWER_BIT  = 0;

    // ------------------------------------------------------------------
    // Host operation codes
    // ------------------------------------------------------------------
    localparam logic [1:0] OP_COMMAND   = 2'h0;
    localparam logic [1:0] OP_WRITE     = 2'h1;
    localparam logic [1:0] OP_READ      = 2'h2;
    localparam logic [1:0] OP_INT_CLEAR = 2'h3;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLOCK_MHZ             = 200;
    localparam int unsigned WARMUP_TIME_US        = 2400;
    localparam int unsigned WARMUP_CYCLES_DEFAULT = WARMUP_TIME_US * CLOCK_MHZ;
    localparam int unsigned WARMUP_COUNT_WIDTH    = 20;

endpackage

/* src/sce_link_if.sv */
// Byte-level link between the host controller and the sensor command logic
`timescale 1ns/1ps
`default_nettype none

interface sce_link_if;
    logic       start;     // First byte of a write frame
    logic       wr_valid;  // Write byte strobe
    logic [7:0] wr_data;
    logic       rd_req;    // Read byte request
    logic       rd_valid;  // Read answer strobe
    logic [7:0] rd_data;

    modport device (
        input  start,
        input  wr_valid,
        input  wr_data,
        input  rd_req,
        output rd_valid,
        output rd_data
    );

    modport host (
        output start,
        output wr_valid,
        output wr_data,
        output rd_req,
        input  rd_valid,
        input  rd_data
    );
endinterface

`default_nettype wire

/* src/sce_device.sv */
// Sensor end: command byte decoder, register pointer and function-enable register
`timescale 1ns/1ps
`default_nettype none

module sce_device
    import sce_pkg::*;
#(
    parameter int unsigned WARMUP_CYCLES = WARMUP_CYCLES_DEFAULT
) (
    input  wire logic       clock_in,
    input  wire logic       srst_in,
    sce_link_if.device      link,
    input  wire logic       conv_event_in,
    output logic            osc_power_on_out,
    output logic            wait_timer_en_out,
    output logic            conv_run_out,
    output logic            color_interrupt_enable_out,
    output logic            color_int_out,
    output logic [4:0]      register_pointer_out,
    output logic [1:0]      access_mode_out
);

    // ------------------------------------------------------------------
    // Byte classification
    // ------------------------------------------------------------------
    logic       command_byte;
    logic       data_byte;
    logic [1:0] cmd_type;
    logic [4:0] cmd_field;
    logic       addressing_cmd;
    logic       int_clear_cmd;
    logic       pointer_step;
    logic       enable_write;
    logic       int_set;
    logic       warm_done;

    logic [4:0] register_pointer_or_special;
    logic [1:0] access_mode;
    logic [7:0] function_enable;
    logic [WARMUP_COUNT_WIDTH-1:0] warm_count;

    // Only the first byte of a write frame can be a command
    assign command_byte = link.wr_valid & link.start & link.wr_data[CMD_FLAG_BIT];
    // A frame opening without the flag is data for the stored pointer
    assign data_byte    = link.wr_valid & ~command_byte;

    assign cmd_type  = link.wr_data[CMD_TYPE_MSB:CMD_TYPE_LSB];
    assign cmd_field = link.wr_data[CMD_FIELD_MSB:CMD_FIELD_LSB];

    // Reserved type is ignored whole so a stray byte cannot move the pointer
    assign addressing_cmd = command_byte
                          & ((cmd_type == TYPE_REPEAT) | (cmd_type == TYPE_AUTO_INC));
    assign int_clear_cmd  = command_byte & (cmd_type == TYPE_SPECIAL)
                          & (cmd_field == SF_INT_CLEAR);

    // Each data byte, read or written, counts as one access
    assign pointer_step = (data_byte | link.rd_req) & (access_mode == TYPE_AUTO_INC);

    assign enable_write = data_byte & (register_pointer_or_special == ADDR_FUNCTION_ENABLE);

    // ------------------------------------------------------------------
    // Register pointer and transaction type
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            register_pointer_or_special <= POINTER_RESET;
            access_mode                 <= TYPE_REPEAT;
        end else if (addressing_cmd) begin
            register_pointer_or_special <= cmd_field;
            access_mode                 <= cmd_type;
        end else if (pointer_step) begin
            // Wraps at the top of the 5-bit space
            register_pointer_or_special <= register_pointer_or_special + 5'h01;
        end
        // Reserved-type and special commands leave both untouched
    end

    // ------------------------------------------------------------------
    // Function-enable register
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            function_enable <= ENABLE_RESET;
        end else if (enable_write) begin
            // Reserved bits never store, so they read back as zero
            function_enable <= link.wr_data & ENABLE_WRITABLE_MASK;
        end
    end

    // ------------------------------------------------------------------
    // Read answer
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            link.rd_valid <= 1'b0;
            link.rd_data  <= UNMAPPED_READ_VALUE;
        end else begin
            link.rd_valid <= link.rd_req;
            if (link.rd_req) begin
                // Other registers live outside this block and read as zero here
                if (register_pointer_or_special == ADDR_FUNCTION_ENABLE) begin
                    link.rd_data <= function_enable;
                end else begin
                    link.rd_data <= UNMAPPED_READ_VALUE;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Oscillator warm-up
    // ------------------------------------------------------------------
    assign warm_done = (warm_count >= WARMUP_COUNT_WIDTH'(WARMUP_CYCLES));

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            warm_count <= '0;
        end else if (!function_enable[EN_OSC_POWER_BIT]) begin
            // Dropping power restarts the full warm-up next time
            warm_count <= '0;
        end else if (!warm_done) begin
            warm_count <= warm_count + WARMUP_COUNT_WIDTH'(1);
        end
    end

    // ------------------------------------------------------------------
    // Function outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            osc_power_on_out           <= 1'b0;
            wait_timer_en_out          <= 1'b0;
            conv_run_out               <= 1'b0;
            color_interrupt_enable_out <= 1'b0;
        end else begin
            osc_power_on_out  <= function_enable[EN_OSC_POWER_BIT];
            // Timers need the oscillator, so both bits must be set
            wait_timer_en_out <= function_enable[EN_WAIT_TIMER_BIT]
                               & function_enable[EN_OSC_POWER_BIT];
            conv_run_out      <= function_enable[EN_CONVERSION_BIT]
                               & function_enable[EN_OSC_POWER_BIT]
                               & warm_done;
            color_interrupt_enable_out <= function_enable[EN_COLOR_INT_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Pending conversion interrupt
    // ------------------------------------------------------------------
    assign int_set = conv_event_in & conv_run_out & function_enable[EN_COLOR_INT_BIT];

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            color_int_out <= 1'b0;
        end else if (int_set) begin
            // A new event beats a clear in the same cycle
            color_int_out <= 1'b1;
        end else if (int_clear_cmd) begin
            // Clear is a single pulse; nothing has to release it
            color_int_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // State visibility
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            register_pointer_out <= POINTER_RESET;
            access_mode_out      <= TYPE_REPEAT;
        end else begin
            register_pointer_out <= register_pointer_or_special;
            access_mode_out      <= access_mode;
        end
    end

endmodule

`default_nettype wire

/* src/sce_host.sv */
// Host end: turns user operations into command, data and read bytes on the link
`timescale 1ns/1ps
`default_nettype none

module sce_host
    import sce_pkg::*;
#(
    parameter int unsigned WARMUP_CYCLES = WARMUP_CYCLES_DEFAULT
) (
    input  wire logic       clock_in,
    input  wire logic       srst_in,
    sce_link_if.host        link,
    input  wire logic       op_valid_in,
    input  wire logic [1:0] op_code_in,
    input  wire logic [1:0] op_type_in,
    input  wire logic [7:0] op_data_in,
    output logic            op_ready_out,
    output logic            op_reject_out,
    output logic            rd_valid_out,
    output logic [7:0]      rd_data_out,
    output logic            results_ready_out
);

    typedef enum logic [2:0] {
        SCE_H_IDLE  = 3'b001,
        SCE_H_ISSUE = 3'b010,
        SCE_H_WAIT  = 3'b100
    } sce_host_state_t;

    sce_host_state_t state;
    logic            accept;
    logic            bad_op;
    logic            is_read;
    logic            step;
    logic [4:0]      ptr_copy;
    logic [1:0]      mode_copy;
    logic            power_seen;
    logic            conv_seen;
    logic [WARMUP_COUNT_WIDTH-1:0] warm_count;

    // Reserved and special transaction types are refused before they reach the link
    assign bad_op = (op_code_in == OP_COMMAND) & (op_type_in != TYPE_REPEAT)
                  & (op_type_in != TYPE_AUTO_INC);
    assign accept = op_valid_in & (state == SCE_H_IDLE) & ~bad_op;
    assign step   = accept & (op_code_in != OP_COMMAND) & (op_code_in != OP_INT_CLEAR)
                  & (mode_copy == TYPE_AUTO_INC);

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            state        <= SCE_H_IDLE;
            op_ready_out <= 1'b1;
            is_read      <= 1'b0;
        end else begin
            case (state)
                SCE_H_IDLE: begin
                    if (accept) begin
                        state        <= SCE_H_ISSUE;
                        op_ready_out <= 1'b0;
                        is_read      <= (op_code_in == OP_READ);
                    end
                end
                SCE_H_ISSUE: begin
                    if (is_read) begin
                        state <= SCE_H_WAIT;
                    end else begin
                        state        <= SCE_H_IDLE;
                        op_ready_out <= 1'b1;
                    end
                end
                SCE_H_WAIT: begin
                    if (link.rd_valid) begin
                        state        <= SCE_H_IDLE;
                        op_ready_out <= 1'b1;
                    end
                end
                default: begin
                    state        <= SCE_H_IDLE;
                    op_ready_out <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Link drive
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            link.start    <= 1'b0;
            link.wr_valid <= 1'b0;
            link.wr_data  <= 8'h00;
            link.rd_req   <= 1'b0;
        end else begin
            link.start    <= 1'b0;
            link.wr_valid <= 1'b0;
            link.rd_req   <= 1'b0;
            if (accept) begin
                case (op_code_in)
                    OP_COMMAND: begin
                        link.start    <= 1'b1;
                        link.wr_valid <= 1'b1;
                        link.wr_data  <= {1'b1, op_type_in, op_data_in[4:0]};
                    end
                    OP_INT_CLEAR: begin
                        link.start    <= 1'b1;
                        link.wr_valid <= 1'b1;
                        link.wr_data  <= {1'b1, TYPE_SPECIAL, SF_INT_CLEAR};
                    end
                    OP_WRITE: begin
                        link.wr_valid <= 1'b1;
                        // Reserved enable bits always go out as zero
                        if (ptr_copy == ADDR_FUNCTION_ENABLE) begin
                            link.wr_data <= op_data_in & ENABLE_WRITABLE_MASK;
                        end else begin
                            link.wr_data <= op_data_in;
                        end
                    end
                    default: begin
                        link.rd_req <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Mirror of the sensor pointer, for masking and warm-up tracking
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            ptr_copy  <= POINTER_RESET;
            mode_copy <= TYPE_REPEAT;
        end else if (accept && op_code_in == OP_COMMAND) begin
            ptr_copy  <= op_data_in[4:0];
            mode_copy <= op_type_in;
        end else if (step) begin
            ptr_copy <= ptr_copy + 5'h01;
        end
    end

    // ------------------------------------------------------------------
    // Results are not expected before the sensor has warmed up
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            power_seen <= 1'b0;
            conv_seen  <= 1'b0;
        end else if (accept && op_code_in == OP_WRITE && ptr_copy == ADDR_FUNCTION_ENABLE) begin
            power_seen <= op_data_in[EN_OSC_POWER_BIT];
            conv_seen  <= op_data_in[EN_CONVERSION_BIT];
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            warm_count        <= '0;
            results_ready_out <= 1'b0;
        end else if (!power_seen) begin
            warm_count        <= '0;
            results_ready_out <= 1'b0;
        end else begin
            if (warm_count < WARMUP_COUNT_WIDTH'(WARMUP_CYCLES)) begin
                warm_count <= warm_count + WARMUP_COUNT_WIDTH'(1);
            end
            results_ready_out <= conv_seen
                               & (warm_count >= WARMUP_COUNT_WIDTH'(WARMUP_CYCLES));
        end
    end

    // ------------------------------------------------------------------
    // User answers
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            op_reject_out <= 1'b0;
            rd_valid_out  <= 1'b0;
            rd_data_out   <= 8'h00;
        end else begin
            op_reject_out <= op_valid_in & (state == SCE_H_IDLE) & bad_op;
            rd_valid_out  <= (state == SCE_H_WAIT) & link.rd_valid;
            if ((state == SCE_H_WAIT) && link.rd_valid) begin
                rd_data_out <= link.rd_data;
            end
        end
    end

endmodule

`default_nettype wire

/* test/sce_link_monitor.sv */
// Checker for the byte link and the function-enable outputs
`timescale 1ns/1ps
`default_nettype none

module sce_link_monitor
    import sce_pkg::*;
(
    input wire logic       clock_in,
    input wire logic       srst_in,
    input wire logic       start,
    input wire logic       wr_valid,
    input wire logic [7:0] wr_data,
    input wire logic       rd_req,
    input wire logic       rd_valid,
    input wire logic [7:0] rd_data,
    input wire logic       conv_event_in,
    input wire logic       osc_power_on_out,
    input wire logic       wait_timer_en_out,
    input wire logic       conv_run_out,
    input wire logic       color_interrupt_enable_out,
    input wire logic       color_int_out,
    input wire logic [4:0] register_pointer_out,
    input wire logic [1:0] access_mode_out
);
    // ------------------------------------------------------------
    // Reference pointer and enable image
    // ------------------------------------------------------------
    logic [4:0] ptr_m;
    logic [1:0] mode_m;
    logic [7:0] en_m;
    logic       cmd;
    logic       dat;

    assign cmd = wr_valid && start && wr_data[7];
    assign dat = (wr_valid && !cmd) || rd_req;

    // Type 10 and special commands leave pointer and type alone
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            ptr_m  <= POINTER_RESET;
            mode_m <= TYPE_REPEAT;
        end else if (cmd && !wr_data[6]) begin
            ptr_m  <= wr_data[4:0];
            mode_m <= wr_data[6:5];
        end else if (dat && mode_m == TYPE_AUTO_INC) begin
            ptr_m <= ptr_m + 5'h01;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            en_m <= ENABLE_RESET;
        end else if (wr_valid && !cmd && ptr_m == ADDR_FUNCTION_ENABLE) begin
            en_m <= wr_data & ENABLE_WRITABLE_MASK;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (srst_in);

    sequence s_clear;
        wr_valid && start && wr_data == {1'b1, TYPE_SPECIAL, SF_INT_CLEAR};
    endsequence

    sequence s_power_up;
        $rose(osc_power_on_out);
    endsequence

    AST_PTR: assert property (register_pointer_out == $past(ptr_m))
        else $error("register pointer off");
    AST_MODE: assert property (access_mode_out == $past(mode_m))
        else $error("access mode off");
    AST_OSC: assert property (osc_power_on_out == $past(en_m[0]))
        else $error("oscillator enable off");
    AST_WAIT: assert property (wait_timer_en_out == $past(en_m[3] & en_m[0]))
        else $error("wait timer enable off");
    AST_IEN: assert property (color_interrupt_enable_out == $past(en_m[4]))
        else $error("interrupt enable off");
    AST_RD_DATA: assert property (rd_req |=> rd_valid && rd_data ==
            ($past(ptr_m) == ADDR_FUNCTION_ENABLE ? $past(en_m) : UNMAPPED_READ_VALUE))
        else $error("read answer wrong");
    AST_RD_QUIET: assert property (!$past(rd_req) |-> !rd_valid)
        else $error("read strobe without request");
    AST_INT_SET: assert property ($rose(color_int_out) |->
            $past(conv_event_in && conv_run_out && en_m[4]))
        else $error("interrupt without enable");
    AST_INT_CLR: assert property (s_clear ##0 !conv_event_in |=> !color_int_out)
        else $error("interrupt not cleared");
    AST_WARMUP: assert property (s_power_up |-> !conv_run_out [*8])
        else $error("conversion before warm-up");
    AST_CONV_OSC: assert property (conv_run_out |-> osc_power_on_out)
        else $error("conversion without oscillator");
endmodule

`default_nettype wire

/* test/sensor_command_and_enable_tb_top.sv */
// Bench joining host and sensor ends over the byte link
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("Error at %0t: got %h expected %h", $time, a, e); end end

module sensor_command_and_enable_tb_top;
    import sce_pkg::*;
    // Short warm-up keeps the run brief
    localparam int unsigned WARM = 20;

    logic       clock_in;
    logic       srst_in;
    logic       op_valid;
    logic       conv_event;
    logic [1:0] op_code;
    logic [1:0] op_type;
    logic [7:0] op_data;
    logic       op_ready;
    logic       op_reject;
    logic       rd_valid;
    logic [7:0] rd_data;
    logic       results_ready;
    logic       osc;
    logic       wait_en;
    logic       conv_run;
    logic       int_en;
    logic       color_int;
    logic [4:0] ptr;
    logic [1:0] mode;
    logic       rj;
    logic [7:0] rdat;
    int         n_errors;
    int         num_checks;

    sce_link_if link();

    sce_host #(.WARMUP_CYCLES(WARM)) u_sce_host (.clock_in(clock_in), .srst_in(srst_in),
        .link(link), .op_valid_in(op_valid), .op_code_in(op_code), .op_type_in(op_type),
        .op_data_in(op_data), .op_ready_out(op_ready), .op_reject_out(op_reject),
        .rd_valid_out(rd_valid), .rd_data_out(rd_data), .results_ready_out(results_ready));

    sce_device #(.WARMUP_CYCLES(WARM)) u_sce_device (.clock_in(clock_in), .srst_in(srst_in),
        .link(link), .conv_event_in(conv_event), .osc_power_on_out(osc),
        .wait_timer_en_out(wait_en), .conv_run_out(conv_run),
        .color_interrupt_enable_out(int_en), .color_int_out(color_int),
        .register_pointer_out(ptr), .access_mode_out(mode));

    sce_link_monitor u_sce_link_monitor (.clock_in(clock_in), .srst_in(srst_in),
        .start(link.start), .wr_valid(link.wr_valid), .wr_data(link.wr_data),
        .rd_req(link.rd_req), .rd_valid(link.rd_valid), .rd_data(link.rd_data),
        .conv_event_in(conv_event), .osc_power_on_out(osc), .wait_timer_en_out(wait_en),
        .conv_run_out(conv_run), .color_interrupt_enable_out(int_en),
        .color_int_out(color_int), .register_pointer_out(ptr), .access_mode_out(mode));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic stop_test;
        $display("Checks: %0d mismatches: %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Presents one host operation and collects refusal and read answer
    task automatic op(input logic [1:0] c, input logic [1:0] t, input logic [7:0] d);
        int k;
        k = 0;
        while (op_ready !== 1'b1 && k < 20) begin
            @(negedge clock_in);
            k++;
        end
        op_valid = 1'b1;
        op_code = c;
        op_type = t;
        op_data = d;
        @(negedge clock_in);
        op_valid = 1'b0;
        rj = 1'b0;
        rdat = 8'hXX;
        repeat (5) begin
            if (op_reject === 1'b1) rj = 1'b1;
            if (rd_valid === 1'b1) rdat = rd_data;
            @(negedge clock_in);
        end
    endtask

    task automatic pulse;
        conv_event = 1'b1;
        @(negedge clock_in);
        conv_event = 1'b0;
        repeat (3) @(negedge clock_in);
    endtask

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end

    initial begin
        #(5000 * 5);
        n_errors++;
        $display("Error at %0t: watchdog expired", $time);
        stop_test();
    end

    initial begin
        srst_in = 1'b1;
        op_valid = 1'b0;
        op_code = OP_COMMAND;
        op_type = TYPE_REPEAT;
        op_data = 8'h00;
        conv_event = 1'b0;
        n_errors = 0;
        num_checks = 0;
        repeat (2) @(posedge clock_in);
        @(negedge clock_in);
        srst_in = 1'b0;
        `CHK(osc, 1'b0)
        `CHK(ptr, POINTER_RESET)
        op(OP_READ, TYPE_REPEAT, 8'h00);
        `CHK(rdat, 8'h00)
        $display("Test reset done");

        op(OP_COMMAND, TYPE_AUTO_INC, 8'h00);
        op(OP_WRITE, TYPE_REPEAT, 8'hFF);
        `CHK(ptr, 5'h01)
        `CHK(mode, TYPE_AUTO_INC)
        `CHK({int_en, wait_en, osc}, 3'h7)
        `CHK(conv_run, 1'b0)
        `CHK(results_ready, 1'b0)
        op(OP_COMMAND, TYPE_REPEAT, 8'h00);
        op(OP_READ, TYPE_REPEAT, 8'h00);
        `CHK(rdat, 8'h1B)
        op(OP_READ, TYPE_REPEAT, 8'h00);
        `CHK(rdat, 8'h1B)
        `CHK(ptr, 5'h00)
        repeat (WARM + 5) @(negedge clock_in);
        `CHK(conv_run, 1'b1)
        `CHK(results_ready, 1'b1)
        $display("Test enable done");

        pulse();
        `CHK(color_int, 1'b1)
        op(OP_COMMAND, TYPE_AUTO_INC, 8'h05);
        op(OP_INT_CLEAR, TYPE_SPECIAL, 8'h00);
        `CHK(color_int, 1'b0)
        `CHK(ptr, 5'h05)
        `CHK(mode, TYPE_AUTO_INC)
        op(OP_COMMAND, TYPE_RESERVED, 8'h03);
        `CHK(rj, 1'b1)
        `CHK(ptr, 5'h05)
        op(OP_COMMAND, TYPE_SPECIAL, {3'h0, SF_INT_CLEAR});
        `CHK(rj, 1'b1)
        $display("Test interrupt done");

        op(OP_COMMAND, TYPE_AUTO_INC, 8'h1F);
        op(OP_READ, TYPE_REPEAT, 8'h00);
        `CHK(rdat, 8'h00)
        `CHK(ptr, 5'h00)
        op(OP_READ, TYPE_REPEAT, 8'h00);
        `CHK(rdat, 8'h1B)
        `CHK(ptr, 5'h01)
        $display("Test wrap done");

        op(OP_COMMAND, TYPE_REPEAT, 8'h00);
        op(OP_WRITE, TYPE_REPEAT, 8'h02);
        `CHK({int_en, wait_en, conv_run, osc}, 4'h0)
        pulse();
        `CHK(color_int, 1'b0)
        op(OP_WRITE, TYPE_REPEAT, 8'h09);
        `CHK({wait_en, osc}, 2'h3)
        `CHK(conv_run, 1'b0)
        $display("Test power done");
        stop_test();
    end
endmodule

`default_nettype wire
